/* shared/tbw_pkg.sv */
// Package with constants and types for the time base operating watchdog.
// *****************************************************************
// Notes on behaviour
// *****************************************************************
// Notes on behaviour
// - Enable and clear bits in second control register.
// - Watchdog clocked by selected time base interrupt clock.
// - Divide by four; overflow while enabled resets.
// - Time-out reset uses the power-on reset vector.
// - Writing one to clear zeroes the divider.
// - Fast source stalls in stop or oscillator off.
// - Slow source keeps counting during stop mode.
// - Rate codes give the four listed time-out ranges.
// - Tap divides time base by 128/4096/8192/16384.
// - Time base clocked by fast or slow oscillator.
package tbw_pkg;
  // Register word offsets (byte addresses).
  localparam logic [3:0] CTRL2_ADR = 4'h0;
  localparam logic [3:0] STAT_ADR = 4'h4;
  localparam logic [3:0] IRQ_STAT_ADR = 4'h8;
  localparam logic [3:0] IRQ_CLR_ADR = 4'hC;
  localparam logic [3:0] IRQ_EN_ADR = 4'h0;
  localparam int ADR_W = 5;
  localparam logic [4:0] IRQ_EN_ADR5 = 5'h10;
  // Control field positions.
  localparam int RATE_LO_BIT = 0;
  localparam int RATE_HI_BIT = 1;
  localparam int WD_EN_BIT = 2;
  localparam int WD_CLR_BIT = 3;
  localparam int SRC_SLOW_BIT = 4;
  localparam int FAST_EN_BIT = 5;
  // Interrupt status bits.
  localparam int EV_TICK = 0;
  localparam int EV_TIMEOUT = 1;
  localparam int EV_W = 2;
  // Time base counter and divider.
  localparam int TB_W = 14;
  localparam int WD_W = 2;
  localparam logic [1:0] WD_LAST = 2'h3;
  localparam logic [1:0] RATE_RST = 2'h0;
  // Tap bit positions: 128, 4096, 8192, 16384.
  localparam int TAP0 = 6;
  localparam int TAP1 = 11;
  localparam int TAP2 = 12;
  localparam int TAP3 = 13;
  // Reset pulse length in system clocks.
  localparam int RST_PULSE_NS = 64;
  localparam int CLK_NS = 8;
  localparam int RST_PULSE_CYC = RST_PULSE_NS / CLK_NS;
  localparam logic [3:0] RST_PULSE_LAST = 4'(RST_PULSE_CYC - 1);

  typedef struct packed {
    logic fast_en;
    logic src_slow;
    logic wd_en;
    logic [1:0] rate;
  } tbw_ctrl_t;

  typedef struct packed {
    logic [4:0] adr;
    logic we;
    logic [31:0] dat;
  } tbw_req_t;
endpackage

/* core/tbw_watchdog.sv */
// Time base watchdog with its Wishbone register slave and interrupt.
`timescale 1ns/1ps
module tbw_watchdog (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic FAST_OSC_CLK_I,
  input wire logic SLOW_OSC_CLK_I,
  input wire logic STOP_MODE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WD_RESET_O,
  output logic TB_TICK_O,
  output logic IRQ_O
);
  // *****************************************************************
  // Oscillator input synchronisers
  // *****************************************************************
  // Both oscillators are far slower than the system clock, so each is
  // sampled through three flops and an edge counts once flops 2 and 3
  // agree on a new level.
  logic [2:0] fast_sync;
  logic [2:0] slow_sync;
  logic fast_lvl;
  logic slow_lvl;
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fast_sync <= 3'h0;
      slow_sync <= 3'h0;
    end else begin
      fast_sync <= {fast_sync[1:0], FAST_OSC_CLK_I};
      slow_sync <= {slow_sync[1:0], SLOW_OSC_CLK_I};
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fast_lvl <= 1'b0;
      slow_lvl <= 1'b0;
    end else begin
      if (fast_sync[1] == fast_sync[2]) begin
        fast_lvl <= fast_sync[2];
      end
      if (slow_sync[1] == slow_sync[2]) begin
        slow_lvl <= slow_sync[2];
      end
    end
  end
  logic fast_rise;
  logic slow_rise;
  assign fast_rise = (fast_sync[1] == fast_sync[2]) && fast_sync[2]
                     && !fast_lvl;
  assign slow_rise = (slow_sync[1] == slow_sync[2]) && slow_sync[2]
                     && !slow_lvl;

  // *****************************************************************
  // Registers
  // *****************************************************************
  tbw_pkg::tbw_ctrl_t ctrl;
  logic [tbw_pkg::EV_W-1:0] ev_stat;
  logic [tbw_pkg::EV_W-1:0] ev_en;
  tbw_pkg::tbw_req_t req;
  logic bus_hit;
  logic wr_go;
  assign req = '{adr: WB_ADR_I, we: WB_WE_I, dat: WB_DAT_I};
  assign bus_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_go = bus_hit && req.we && WB_SEL_I[0];

  function automatic logic is_adr(input logic [4:0] a,
                                  input logic [4:0] b);
    is_adr = (a == b);
  endfunction

  logic clr_strobe;
  // A one written to the clear bit pulses once and is never stored.
  assign clr_strobe = wr_go && is_adr(req.adr, {1'b0, tbw_pkg::CTRL2_ADR})
                      && req.dat[tbw_pkg::WD_CLR_BIT];

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl <= '{fast_en: 1'b1, src_slow: 1'b1, wd_en: 1'b0,
                rate: tbw_pkg::RATE_RST};
    end else if (wr_go && is_adr(req.adr, {1'b0, tbw_pkg::CTRL2_ADR})) begin
      ctrl.rate <= {req.dat[tbw_pkg::RATE_HI_BIT],
                    req.dat[tbw_pkg::RATE_LO_BIT]};
      ctrl.wd_en <= req.dat[tbw_pkg::WD_EN_BIT];
      ctrl.src_slow <= req.dat[tbw_pkg::SRC_SLOW_BIT];
      ctrl.fast_en <= req.dat[tbw_pkg::FAST_EN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ev_en <= '0;
    end else if (wr_go && is_adr(req.adr, tbw_pkg::IRQ_EN_ADR5)) begin
      ev_en <= req.dat[tbw_pkg::EV_W-1:0];
    end
  end

  // *****************************************************************
  // Time base and watchdog divider
  // *****************************************************************
  logic [tbw_pkg::TB_W-1:0] tb_cnt;
  logic tb_step;
  logic [tbw_pkg::TB_W-1:0] next_tb;
  logic tick;
  // The fast source halts in stop mode or with its enable low; the slow
  // crystal always runs, which is why software should pick it.
  assign tb_step = ctrl.src_slow ? slow_rise
                   : (fast_rise && ctrl.fast_en && !STOP_MODE_I);
  assign next_tb = tb_cnt + 1'b1;

  function automatic logic tap_rolls(input logic [1:0] rate,
                                     input logic [13:0] cur,
                                     input logic [13:0] nxt);
    logic [13:0] fall;
    fall = cur & ~nxt;
    unique case (rate)
      2'h0: tap_rolls = fall[tbw_pkg::TAP0];
      2'h1: tap_rolls = fall[tbw_pkg::TAP1];
      2'h2: tap_rolls = fall[tbw_pkg::TAP2];
      2'h3: tap_rolls = fall[tbw_pkg::TAP3];
    endcase
  endfunction

  // A tap bit falling marks one period of 2 x 2^tap = 128..16384 counts.
  assign tick = tb_step && tap_rolls(ctrl.rate, tb_cnt, next_tb);

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tb_cnt <= '0;
    end else if (tb_step) begin
      tb_cnt <= next_tb;
    end
  end

  logic [tbw_pkg::WD_W-1:0] wd_cnt;
  logic overflow;
  assign overflow = tick && (wd_cnt == tbw_pkg::WD_LAST) && ctrl.wd_en;
  // Clear takes priority over a coincident tick, so servicing right at
  // the boundary still avoids the reset.  The divider is a two-bit count,
  // so four ticks give the 3..4 tick window of the time-out table.
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wd_cnt <= '0;
    end else if (clr_strobe) begin
      wd_cnt <= '0;
    end else if (tick) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // *****************************************************************
  // Reset pulse
  // *****************************************************************
  // The pulse drives the same system reset line as power-on and the
  // external pin, so the core fetches the common reset vector.
  logic [3:0] rst_cnt;
  logic rst_act;
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_act <= 1'b0;
      rst_cnt <= 4'h0;
    end else if (overflow && !clr_strobe) begin
      rst_act <= 1'b1;
      rst_cnt <= 4'h0;
    end else if (rst_act) begin
      rst_cnt <= rst_cnt + 1'b1;
      if (rst_cnt == tbw_pkg::RST_PULSE_LAST) begin
        rst_act <= 1'b0;
      end
    end
  end
  assign WD_RESET_O = rst_act;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TB_TICK_O <= 1'b0;
    end else begin
      TB_TICK_O <= tick;
    end
  end

  // *****************************************************************
  // Interrupt status
  // *****************************************************************
  logic [tbw_pkg::EV_W-1:0] ev_set;
  logic [tbw_pkg::EV_W-1:0] ev_clr;
  assign ev_set = {overflow && !clr_strobe, tick};
  assign ev_clr = (wr_go && is_adr(req.adr, {1'b0, tbw_pkg::IRQ_CLR_ADR}))
                  ? req.dat[tbw_pkg::EV_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ev_stat <= '0;
    end else begin
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
    end
  end
  assign IRQ_O = |(ev_stat & ev_en);

  // *****************************************************************
  // Read path and acknowledge
  // *****************************************************************
  logic [31:0] next_rd;
  always_comb begin
    next_rd = 32'h0;
    unique case (req.adr)
      {1'b0, tbw_pkg::CTRL2_ADR}: begin
        next_rd[tbw_pkg::RATE_LO_BIT] = ctrl.rate[0];
        next_rd[tbw_pkg::RATE_HI_BIT] = ctrl.rate[1];
        next_rd[tbw_pkg::WD_EN_BIT] = ctrl.wd_en;
        next_rd[tbw_pkg::SRC_SLOW_BIT] = ctrl.src_slow;
        next_rd[tbw_pkg::FAST_EN_BIT] = ctrl.fast_en;
      end
      {1'b0, tbw_pkg::STAT_ADR}: begin
        next_rd[tbw_pkg::TB_W-1:0] = tb_cnt;
        next_rd[tbw_pkg::TB_W+tbw_pkg::WD_W-1:tbw_pkg::TB_W] = wd_cnt;
      end
      {1'b0, tbw_pkg::IRQ_STAT_ADR}: next_rd[tbw_pkg::EV_W-1:0] = ev_stat;
      tbw_pkg::IRQ_EN_ADR5: next_rd[tbw_pkg::EV_W-1:0] = ev_en;
      default: next_rd = 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= bus_hit;
      WB_DAT_O <= (bus_hit && !req.we) ? next_rd : 32'h0;
    end
  end

  // *****************************************************************
  // Assertions
  // *****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  // Watchdog divider and reset pulse.
  // A clear in the overflow cycle must win, or servicing exactly at the
  // boundary would still reset the part.
  clear_zeroes_divider_a: assert property (
    clr_strobe |=> wd_cnt == 2'h0)
    else $error("divider not zero after clear");
  disabled_no_reset_a: assert property (
    !ctrl.wd_en && !rst_act |=> !rst_act)
    else $error("reset raised while watchdog disabled");
  overflow_resets_a: assert property (
    overflow && !clr_strobe |=> rst_act [*8] ##1 !rst_act)
    else $error("reset pulse wrong length");
  service_wins_a: assert property (
    overflow && clr_strobe && !rst_act |=> !rst_act)
    else $error("reset raised despite clear");
  no_stray_reset_a: assert property (
    !overflow && !rst_act |=> !rst_act)
    else $error("reset raised without overflow");
  divider_advances_a: assert property (
    tick && !clr_strobe |=> wd_cnt == $past(wd_cnt) + 2'h1)
    else $error("divider did not advance");
  divider_holds_a: assert property (
    !tick && !clr_strobe |=> wd_cnt == $past(wd_cnt))
    else $error("divider moved without tick");
  zero_write_keeps_a: assert property (
    wr_go && !clr_strobe && !tick |=> wd_cnt == $past(wd_cnt))
    else $error("zero write changed divider");
  enable_write_a: assert property (
    wr_go && req.adr == {1'b0, tbw_pkg::CTRL2_ADR}
    |=> ctrl.wd_en == $past(req.dat[tbw_pkg::WD_EN_BIT]))
    else $error("enable bit not written");

  // Time base source and taps.  Each rate code is checked at its own tap
  // so that a wrong select in the tap mux cannot hide behind another rate.
  fast_stalls_a: assert property (
    !ctrl.src_slow && (STOP_MODE_I || !ctrl.fast_en) |-> !tb_step)
    else $error("fast source counted while halted");
  slow_runs_a: assert property (
    ctrl.src_slow && slow_rise |=> tb_cnt == $past(tb_cnt) + 14'h1)
    else $error("slow source did not count");
  fast_runs_a: assert property (
    !ctrl.src_slow && ctrl.fast_en && !STOP_MODE_I && fast_rise
    |=> tb_cnt == $past(tb_cnt) + 14'h1)
    else $error("fast source did not count");
  tb_holds_a: assert property (
    !tb_step |=> tb_cnt == $past(tb_cnt))
    else $error("time base moved without step");
  tick_on_step_a: assert property (
    tick |-> tb_step)
    else $error("tick without time base step");
  tick_output_a: assert property (
    tick |=> TB_TICK_O)
    else $error("tick output missing");
  rate0_tap_a: assert property (
    ctrl.rate == 2'h0 && tick |-> tb_cnt[6:0] == 7'h7F)
    else $error("rate zero tick off its tap");
  rate1_tap_a: assert property (
    ctrl.rate == 2'h1 && tick |-> tb_cnt[11:0] == 12'hFFF)
    else $error("rate one tick off its tap");
  rate2_tap_a: assert property (
    ctrl.rate == 2'h2 && tick |-> tb_cnt[12:0] == 13'h1FFF)
    else $error("rate two tick off its tap");
  rate3_tap_a: assert property (
    ctrl.rate == 2'h3 && tick |-> tb_cnt == 14'h3FFF)
    else $error("rate three tick off its tap");

  // Interrupt status and bus handshake.
  tick_sets_flag_a: assert property (
    tick |=> ev_stat[tbw_pkg::EV_TICK])
    else $error("tick flag not set");
  timeout_flag_a: assert property (
    overflow && !clr_strobe |=> ev_stat[tbw_pkg::EV_TIMEOUT])
    else $error("time-out flag not set");
  status_sticky_a: assert property (
    ev_stat[tbw_pkg::EV_TICK] && !ev_clr[tbw_pkg::EV_TICK]
    |=> ev_stat[tbw_pkg::EV_TICK])
    else $error("tick flag lost without clear");
  clear_works_a: assert property (
    ev_clr[tbw_pkg::EV_TICK] && !tick |=> !ev_stat[tbw_pkg::EV_TICK])
    else $error("tick flag not cleared");
  ack_one_cycle_a: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  ack_answers_a: assert property (
    bus_hit |=> WB_ACK_O)
    else $error("request not acknowledged");
  rdata_idle_zero_a: assert property (
    !WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside acknowledge");
  clear_reads_zero_a: assert property (
    WB_ACK_O && req.adr == {1'b0, tbw_pkg::CTRL2_ADR}
    |-> !WB_DAT_O[tbw_pkg::WD_CLR_BIT])
    else $error("clear bit read back as one");

  // Cover points for the main scenarios.
  timeout_c: cover property (overflow);
  service_c: cover property (clr_strobe && wd_cnt == 2'h3);
  fast_stop_c: cover property (!ctrl.src_slow && STOP_MODE_I);
  irq_c: cover property (IRQ_O);
  rate3_c: cover property (ctrl.rate == 2'h3 && tick);
endmodule

/* sim/testbench.sv */
// Self-checking bench for the time base watchdog, with a behavioural model.
`timescale 1ns/1ps
module testbench;
  logic clk, rst_b, fosc, sosc, stop, cyc, stb, we, ack, wdr, tick, irq;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, rd;
  int n_mismatch, checked, cyc_cnt, m_tick, d_tick, m_to, d_to, run;
  int tb, wd, rate, en, slow, fast, ist, ien;

  tbw_watchdog i_tbw_watchdog (.SYS_CLK_I(clk), .RST_B_I(rst_b),
    .FAST_OSC_CLK_I(fosc), .SLOW_OSC_CLK_I(sosc), .STOP_MODE_I(stop),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .WD_RESET_O(wdr), .TB_TICK_O(tick), .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // *****************************************************************
  // Comparisons and bus cycles
  // *****************************************************************
  task automatic stop_test();
    $display("Mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t no acknowledge", $time);
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic set_ctrl(input int r, e, c, s, f);
    logic [31:0] d;
    d = 32'h0;
    d[tbw_pkg::RATE_LO_BIT] = r[0];
    d[tbw_pkg::RATE_HI_BIT] = r[1];
    d[tbw_pkg::WD_EN_BIT] = e[0];
    d[tbw_pkg::WD_CLR_BIT] = c[0];
    d[tbw_pkg::SRC_SLOW_BIT] = s[0];
    d[tbw_pkg::FAST_EN_BIT] = f[0];
    wb(5'(tbw_pkg::CTRL2_ADR), 1'b1, d);
    rate = r;
    en = e;
    slow = s;
    fast = f;
    if (c != 0) wd = 0;
  endtask

  // *****************************************************************
  // Model of the time base and the watchdog divider
  // *****************************************************************
  task automatic step();
    int o, b;
    o = tb;
    tb = (tb + 1) % 16384;
    b = (rate == 0) ? 6 : 10 + rate;
    if (o[b] && !tb[b]) begin
      m_tick++;
      ist |= 1;
      wd = (wd + 1) % 4;
      if (wd == 0 && en != 0) begin
        m_to++;
        ist |= 2;
      end
    end
  endtask

  // Each oscillator pulse is high for two of its four system clocks so the synchroniser sees it.
  task automatic edges(input int n, input bit fst);
    repeat (n) begin
      @(posedge clk);
      if (fst) fosc <= 1'b1;
      else sosc <= 1'b1;
      repeat (2) @(posedge clk);
      fosc <= 1'b0;
      sosc <= 1'b0;
      @(posedge clk);
      if (fst ? (slow == 0 && stop !== 1'b1 && fast != 0) : slow != 0) step();
    end
  endtask

  task automatic check_all();
    repeat (20) @(posedge clk);
    wb(5'(tbw_pkg::STAT_ADR), 1'b0, 32'h0);
    chk_reg(rd, 32'(wd * 16384 + tb));
    wb(5'(tbw_pkg::IRQ_STAT_ADR), 1'b0, 32'h0);
    chk_reg(rd, 32'(ist));
    chk_reg({31'h0, irq}, 32'((ist & ien) != 0));
    chk_cnt(d_tick, m_tick);
    chk_cnt(d_to, m_to);
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (tick === 1'b1) d_tick++;
    if (wdr === 1'b1) run++;
    else if (run > 0) begin
      d_to++;
      chk_cnt(run, 8);
      run = 0;
    end
    if (cyc_cnt == 95000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // *****************************************************************
  // Main sequence
  // *****************************************************************
  initial begin
    rst_b = 1'b0;
    {fosc, sosc, stop, cyc, stb, we} = 6'h00;
    adr = 5'h00;
    sel = 4'h0;
    dw = 32'h0;
    slow = 1;
    fast = 1;
    void'($urandom(41511));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wb(5'(tbw_pkg::CTRL2_ADR), 1'b0, 32'h0);
    chk_reg(rd, 32'h00000030);
    wb(5'h14, 1'b0, 32'h0);
    chk_reg(rd, 32'h00000000);
    wb(5'(tbw_pkg::STAT_ADR), 1'b1, 32'hFFFFFFFF);
    edges($urandom_range(200, 130), 1'b0);
    check_all();
    wb(tbw_pkg::IRQ_EN_ADR5, 1'b1, 32'h3);
    ien = 3;
    wb(tbw_pkg::IRQ_EN_ADR5, 1'b0, 32'h0);
    chk_reg(rd, 32'h00000003);
    check_all();
    wb(5'(tbw_pkg::IRQ_CLR_ADR), 1'b1, 32'h3);
    ist = 0;
    check_all();
    set_ctrl(0, 0, 0, 0, 1);
    stop <= 1'b1;
    edges(50, 1'b1);
    edges(50, 1'b0);
    stop <= 1'b0;
    set_ctrl(0, 0, 0, 0, 0);
    edges(50, 1'b1);
    check_all();
    set_ctrl(0, 0, 0, 0, 1);
    edges($urandom_range(300, 200), 1'b1);
    check_all();
    set_ctrl(0, 1, 0, 1, 1);
    stop <= 1'b1;
    edges(384, 1'b0);
    set_ctrl(0, 1, 1, 1, 1);
    stop <= 1'b0;
    wb(5'(tbw_pkg::CTRL2_ADR), 1'b0, 32'h0);
    chk_reg(rd, 32'h00000034);
    edges(256, 1'b0);
    check_all();
    set_ctrl(0, 1, 0, 1, 1);
    edges(300, 1'b0);
    check_all();
    for (int r = 1; r < 4; r++) begin
      set_ctrl(r, 0, 0, 1, 1);
      edges(r == 3 ? 8192 : 4096, 1'b0);
      check_all();
    end
    stop_test();
  end
endmodule
